// ===== design/cad_datapath.sv
// carry add datapath: decode, register file sequencing, flags, bus slave
// Summary of operation
// - add-carrying writes the sum of the first and second source registers to the target.
// - every add-carrying form loads the carry flag with the carry out of the add.
// - add-extended writes both sources plus the current carry flag to the target.
// - every add-extended form loads the carry flag with the carry out of that add.
// - with overflow-enable set, overflow and summary overflow update; otherwise both hold.
// - with record-enable set, condition field 0 takes sign, zero and summary overflow.
module cad_datapath #(
   parameter int GPR_DEPTH = cad_pkg::GPR_DEPTH
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [cad_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq
);

   // ****************************************
   // elaboration checks
   // ****************************************
   if (GPR_DEPTH != (1 << cad_pkg::GPR_IDX_W)) begin : g_chk
      $error("cad_datapath: register file depth must fill the index");
   end

   // the bus word and the adder share one width
   if (cad_pkg::DATA_W != 32) begin : g_chk_w
      $error("cad_datapath: data width must be 32");
   end

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic wreq;
      logic [31:0] rdata;
      logic irq;
      cad_pkg::cad_state_type st;
      logic mem_pend;
      logic [31:0] instr;
      logic [31:0] opa;
      logic [31:0] result;
      cad_pkg::cad_xer_type xer;
      cad_pkg::cad_cr0_type cr0;
      logic [cad_pkg::IRQ_W-1:0] irq_stat;
      logic [cad_pkg::IRQ_W-1:0] irq_en;
   } cad_top_st_type;

   cad_top_st_type r;
   cad_top_st_type next_r;

   logic mem_we;
   logic [3:0] mem_be;
   logic [cad_pkg::GPR_IDX_W-1:0] mem_addr;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;
   logic add_start;
   logic [31:0] add_b;
   logic add_cin;
   cad_pkg::cad_sum_type add_res;

   logic acc;
   logic is_gpr;
   logic [31:0] wmask;
   logic [cad_pkg::IRQ_W-1:0] ev;
   logic [cad_pkg::IRQ_W-1:0] clr;
   logic [5:0] f_opcd;
   logic [8:0] f_xo;
   logic f_oe;
   logic f_rc;
   logic f_ext;
   logic [4:0] f_rt;
   logic [4:0] f_ra;
   logic [4:0] f_rb;

   // ****************************************
   // instruction fields of the held word
   // ****************************************
   assign f_opcd = r.instr[cad_pkg::OPCD_LSB +: 6];
   assign f_xo = r.instr[cad_pkg::XO_LSB +: 9];
   assign f_oe = r.instr[cad_pkg::OE_BIT];
   assign f_rc = r.instr[cad_pkg::RC_BIT];
   assign f_ext = (f_opcd == cad_pkg::OPCD_ARITH) && (f_xo == cad_pkg::XO_ADD_EXTENDED);
   assign f_rt = r.instr[cad_pkg::RT_LSB +: 5];
   assign f_ra = r.instr[cad_pkg::RA_LSB +: 5];
   assign f_rb = r.instr[cad_pkg::RB_LSB +: 5];

   // ****************************************
   // bus request qualification
   // ****************************************
   // a request is taken only while waitrequest is high, the sequencer
   // is idle and no register file read is pending, so the single
   // register file port is never shared
   // (the master never raises read and write together)
   assign acc = (avs_read || avs_write) && r.wreq && (r.st == cad_pkg::CAD_IDLE)
                && !r.mem_pend;
   assign is_gpr = (avs_address >= cad_pkg::OFF_GPR_BASE);

   // write data merged into a zero word under byte enables
   assign wmask = cad_pkg::cad_merge(cad_pkg::RST_WORD, avs_writedata, avs_byteenable);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.wreq = 1'b1;
      ev = '0;
      clr = '0;
      mem_we = 1'b0;
      mem_be = cad_pkg::BE_ALL;
      mem_addr = avs_address[2 +: cad_pkg::GPR_IDX_W];
      mem_wdata = avs_writedata;
      add_start = 1'b0;
      add_b = mem_rdata;
      add_cin = 1'b0;

      // answer of a pending register file read
      if (r.mem_pend) begin
         next_r.rdata = mem_rdata;
         next_r.wreq = 1'b0;
         next_r.mem_pend = 1'b0;
      end else if (acc) begin
         next_r.wreq = 1'b0;
         next_r.rdata = cad_pkg::RST_WORD;
         if (avs_read) begin
            // register reads, unmapped addresses read zero
            if (is_gpr) begin
               next_r.wreq = 1'b1; // data arrive one cycle later
               next_r.mem_pend = 1'b1;
            end else if (avs_address == cad_pkg::OFF_INSTR) begin
               next_r.rdata = r.instr;
            end else if (avs_address == cad_pkg::OFF_FLAGS) begin
               next_r.rdata = {29'h0000_0000, r.xer};
            end else if (avs_address == cad_pkg::OFF_CR0) begin
               next_r.rdata = {28'h0000_0000, r.cr0};
            end else if (avs_address == cad_pkg::OFF_RESULT) begin
               next_r.rdata = r.result;
            end else if (avs_address == cad_pkg::OFF_STATUS) begin
               next_r.rdata = {31'h0000_0000, r.st != cad_pkg::CAD_IDLE};
            end else if (avs_address == cad_pkg::OFF_IRQ_STAT) begin
               next_r.rdata = {29'h0000_0000, r.irq_stat};
            end else if (avs_address == cad_pkg::OFF_IRQ_EN) begin
               next_r.rdata = {29'h0000_0000, r.irq_en};
            end
         end else begin
            // register writes, unmapped and read-only addresses ignore data
            if (is_gpr) begin
               mem_we = 1'b1;
               mem_be = avs_byteenable;
            end else if (avs_address == cad_pkg::OFF_INSTR) begin
               next_r.instr = wmask;
               // launch only a recognised add, flag anything else
               if (wmask[cad_pkg::OPCD_LSB +: 6] == cad_pkg::OPCD_ARITH &&
                   (wmask[cad_pkg::XO_LSB +: 9] == cad_pkg::XO_ADD_CARRYING ||
                    wmask[cad_pkg::XO_LSB +: 9] == cad_pkg::XO_ADD_EXTENDED)) begin
                  next_r.st = cad_pkg::CAD_RD_A;
               end else begin
                  ev[cad_pkg::IRQ_BAD] = 1'b1;
               end
            end else if (avs_address == cad_pkg::OFF_FLAGS) begin
               // only byte lane 0 carries the three flag bits
               if (avs_byteenable[0]) begin
                  next_r.xer = cad_pkg::cad_xer_type'(avs_writedata[2:0]);
               end
            end else if (avs_address == cad_pkg::OFF_IRQ_CLR) begin
               clr = wmask[cad_pkg::IRQ_W-1:0];
            end else if (avs_address == cad_pkg::OFF_IRQ_EN) begin
               next_r.irq_en = wmask[cad_pkg::IRQ_W-1:0];
            end
         end
      end

      // instruction sequencer: one register file port serves both reads,
      // so the sources come on successive cycles and the add follows
      // once the second word stands on the read port
      case (r.st)
         cad_pkg::CAD_IDLE: begin
         end
         cad_pkg::CAD_RD_A: begin
            // fetch the first source
            mem_addr = f_ra;
            next_r.st = cad_pkg::CAD_RD_B;
         end
         cad_pkg::CAD_RD_B: begin
            // first source arrives, fetch the second
            mem_addr = f_rb;
            next_r.opa = mem_rdata;
            next_r.st = cad_pkg::CAD_EXEC;
         end
         cad_pkg::CAD_EXEC: begin
            // add both sources, plus carry only in the extended form
            mem_addr = f_rb;
            add_start = 1'b1;
            add_b = mem_rdata;
            add_cin = f_ext && r.xer.carry_flag;
            next_r.st = cad_pkg::CAD_WB;
         end
         cad_pkg::CAD_WB: begin
            // write the sum back and update flags
            // target and result register get the same sum
            mem_addr = f_rt;
            mem_we = 1'b1;
            mem_be = cad_pkg::BE_ALL;
            mem_wdata = add_res.sum;
            next_r.result = add_res.sum;
            // carry loads in every form of both ops
            next_r.xer.carry_flag = add_res.carry;
            if (f_ext) begin
               next_r.xer.carry_flag = add_res.carry;
            end
            // overflow and summary overflow move only with overflow-enable
            if (f_oe) begin
               next_r.xer.overflow_flag = add_res.ovf;
               next_r.xer.so = r.xer.so || add_res.ovf;
               ev[cad_pkg::IRQ_OVF] = add_res.ovf;
            end
            // condition field only with record-enable, after the so update
            if (f_rc) begin
               next_r.cr0 = cad_pkg::cad_cr0_of(add_res.sum, next_r.xer.so);
            end
            ev[cad_pkg::IRQ_DONE] = 1'b1;
            next_r.st = cad_pkg::CAD_IDLE;
         end
         default: begin
            next_r.st = cad_pkg::CAD_IDLE;
         end
      endcase

      // sticky interrupt status, a new event wins over a clear
      // irq is built from the next values so it rises with the event
      next_r.irq_stat = (r.irq_stat & ~clr) | ev;
      next_r.irq = |(next_r.irq_stat & next_r.irq_en);
   end

   // ****************************************
   // state register
   // ****************************************
   // reset branch loads constants only
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r.wreq <= 1'b1;
         r.rdata <= cad_pkg::RST_WORD;
         r.irq <= 1'b0;
         r.st <= cad_pkg::CAD_IDLE;
         r.mem_pend <= 1'b0;
         r.instr <= cad_pkg::RST_WORD;
         r.opa <= cad_pkg::RST_WORD;
         r.result <= cad_pkg::RST_WORD;
         r.xer <= '0;
         r.cr0 <= '0;
         r.irq_stat <= cad_pkg::RST_IRQ;
         r.irq_en <= cad_pkg::RST_IRQ;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // sub-blocks
   // ****************************************
   // general registers, one port shared by bus and sequencer
   // the bus reaches it only while the sequencer is idle
   cad_gpr_mem #(
      .DEPTH(GPR_DEPTH),
      .IDX_W(cad_pkg::GPR_IDX_W)
   ) u_gpr (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .wr_en(mem_we),
      .wr_be(mem_be),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // adder, result registered one cycle after start
   // carry in is the flag as it stood when the add began in the extended form, zero in the carrying form
   cad_add_unit u_add (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .start(add_start),
      .a(r.opa),
      .b(add_b),
      .cin(add_cin),
      .res(add_res)
   );

   // outputs straight from the state register
   // so waitrequest, read data and irq never glitch
   assign avs_readdata = r.rdata;
   assign avs_waitrequest = r.wreq;
   assign irq = r.irq;

endmodule : cad_datapath

// ===== design/cad_pkg.sv
// constants, types and helpers shared by the carry add datapath
package cad_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int GPR_DEPTH = 32;
   localparam int GPR_IDX_W = 5;
   localparam int IRQ_W = 3;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_FLAGS = 8'h04;
   localparam logic [7:0] OFF_CR0 = 8'h08;
   localparam logic [7:0] OFF_RESULT = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
   localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
   localparam logic [7:0] OFF_GPR_BASE = 8'h80;

   // ****************************************
   // instruction word fields, bit 0 is the least significant bit
   // ****************************************
   localparam int OPCD_LSB = 26;
   localparam int RT_LSB = 21;
   localparam int RA_LSB = 16;
   localparam int RB_LSB = 11;
   localparam int OE_BIT = 10;
   localparam int XO_LSB = 1;
   localparam int RC_BIT = 0;
   localparam logic [5:0] OPCD_ARITH = 6'h1f;
   localparam logic [8:0] XO_ADD_CARRYING = 9'h00a;
   localparam logic [8:0] XO_ADD_EXTENDED = 9'h08a;

   // ****************************************
   // interrupt bits and reset values
   // ****************************************
   localparam int IRQ_DONE = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_BAD = 2;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [2:0] RST_IRQ = 3'h0;
   localparam logic [3:0] BE_ALL = 4'hf;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      CAD_IDLE = 3'h0,
      CAD_RD_A = 3'h1,
      CAD_RD_B = 3'h3,
      CAD_EXEC = 3'h2,
      CAD_WB = 3'h6
   } cad_state_type;

   // fixed-point exception flags, read at OFF_FLAGS bits 2:0
   typedef struct packed {
      logic so;
      logic overflow_flag;
      logic carry_flag;
   } cad_xer_type;

   // condition field 0, read at OFF_CR0 bits 3:0
   typedef struct packed {
      logic negative_result_bit;
      logic positive_result_bit;
      logic zero_result_bit;
      logic so;
   } cad_cr0_type;

   // adder result as it leaves the add unit
   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] sum;
      logic carry;
      logic ovf;
   } cad_sum_type;

   // merge a bus write into an old word under byte enables
   function automatic logic [31:0] cad_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] be);
      logic [31:0] m;
      m = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return m;
   endfunction : cad_merge

   // condition field from a result and the summary overflow
   function automatic cad_cr0_type cad_cr0_of(input logic [31:0] res,
                                              input logic so);
      cad_cr0_type c;
      c.negative_result_bit = res[31];
      c.positive_result_bit = !res[31] && (res != RST_WORD);
      c.zero_result_bit = (res == RST_WORD);
      c.so = so;
      return c;
   endfunction : cad_cr0_of

endpackage : cad_pkg

// ===== design/cad_gpr_mem.sv
// general register file with byte enables and registered read data
module cad_gpr_mem #(
   parameter int DEPTH = cad_pkg::GPR_DEPTH,
   parameter int IDX_W = cad_pkg::GPR_IDX_W
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [3:0] wr_be,
   input wire logic [IDX_W-1:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);

   // refuse a depth the index cannot reach
   if (DEPTH > (1 << IDX_W) || DEPTH < 2) begin : g_chk
      $error("cad_gpr_mem: bad depth");
   end

   typedef struct packed {
      logic [DEPTH-1:0][31:0] mem;
      logic [31:0] rdata;
   } cad_mem_st_type;

   cad_mem_st_type r;
   cad_mem_st_type next_r;

   // write under byte enables, read of the old word
   always_comb begin
      next_r = r;
      next_r.rdata = r.mem[addr];
      if (wr_en) begin
         next_r.mem[addr] = cad_pkg::cad_merge(r.mem[addr], wdata, wr_be);
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rdata = r.rdata;

endmodule : cad_gpr_mem

// ===== design/cad_add_unit.sv
// registered three-input adder with carry and signed overflow out
module cad_add_unit (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [cad_pkg::DATA_W-1:0] a,
   input wire logic [cad_pkg::DATA_W-1:0] b,
   input wire logic cin,
   output cad_pkg::cad_sum_type res
);

   localparam int W = cad_pkg::DATA_W;

   cad_pkg::cad_sum_type r;
   cad_pkg::cad_sum_type next_r;
   logic [W:0] ext;

   // one add per start, result valid one cycle later
   always_comb begin
      ext = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
      next_r = r;
      next_r.valid = start;
      if (start) begin
         next_r.sum = ext[W-1:0];
         next_r.carry = ext[W];
         next_r.ovf = (a[W-1] == b[W-1]) && (ext[W-1] != a[W-1]);
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign res = r;

endmodule : cad_add_unit

// ===== sim/cad_host_model.sv
// bus master model standing in for the decoder and register file side
module cad_host_model (
   input wire logic sys_clk,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [3:0] avs_byteenable,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] be_next = 4'hf; // byte lanes of the next transfer

   // idle lines carry a pattern, never a stale request
   initial begin
      avs_address = 8'h5a;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'hf;
      avs_writedata = 32'ha5a5_a5a5;
   end

   // one transfer: call right after a rising edge, holds until waitrequest low
   task automatic bus_op(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                         output logic [31:0] rdata);
      avs_address <= addr;
      avs_writedata <= data;
      avs_byteenable <= be_next;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~addr; // released lines show the inverse
      avs_writedata <= ~data;
      @(posedge sys_clk);
   endtask : bus_op
endmodule : cad_host_model

// ===== sim/cad_datapath_asserts.sv
// port level checker for the carry add datapath
module cad_datapath_asserts #(
   parameter int GPR_DEPTH = cad_pkg::GPR_DEPTH
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [cad_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic [3:0] since_wr;

   // cycles since a write last stood on the bus, saturating
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         since_wr <= 4'hf;
      end else if (avs_write) begin
         since_wr <= 4'h0;
      end else if (since_wr != 4'hf) begin
         since_wr <= since_wr + 4'h1;
      end
   end

   sequence s_rd_at(logic [7:0] adr);
      avs_read && !avs_waitrequest && (avs_address == adr);
   endsequence
   sequence s_en_off;
      avs_write && !avs_waitrequest && (avs_address == cad_pkg::OFF_IRQ_EN)
         && (avs_writedata == 32'h0000_0000) && (avs_byteenable == 4'hf);
   endsequence

   a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_ack_needs_req: assert property (!avs_waitrequest |-> (avs_read || avs_write))
      else $error("answer without a request");
   a_ack_bounded: assert property ((avs_read || avs_write) |-> ##[0:12] !avs_waitrequest)
      else $error("request not answered in time");
   a_flags_clean: assert property (s_rd_at(cad_pkg::OFF_FLAGS) |->
      avs_readdata[31:3] == 29'h0000_0000) else $error("flags word has stray bits");
   a_cr0_onehot: assert property (s_rd_at(cad_pkg::OFF_CR0) |->
      (avs_readdata[31:4] == 28'h000_0000) && $onehot0(avs_readdata[3:1]))
      else $error("condition field not one of less, greater, equal");
   a_status_idle: assert property (s_rd_at(cad_pkg::OFF_STATUS) |->
      avs_readdata == 32'h0000_0000) else $error("status busy when answered");
   a_irq_cause: assert property ($rose(irq) |-> since_wr <= 4'h8)
      else $error("interrupt without a recent write");
   a_irq_mask_off: assert property (s_en_off |-> ##2 !irq)
      else $error("interrupt stays up with enables cleared");
endmodule : cad_datapath_asserts

// ===== sim/tb_cad_datapath.sv
// self-checking bench for the carry add datapath
module tb_cad_datapath;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk;
   logic nrst;
   logic [7:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   int errors;
   int check_count;
   int cycles;
   int seed;
   logic [31:0] gpr [32];
   logic carry;
   logic ovf;
   logic so;
   logic ovf_seen;
   logic [3:0] cr0;
   logic [31:0] rnd;
   logic [31:0] ca [5] = '{32'h9000_3000, 32'h7fff_ffff, 32'hffff_ffff, 32'h8000_0000,
                           32'h1000_0400};
   logic [31:0] cb [5] = '{32'h8000_7000, 32'h0000_0001, 32'h0000_0001, 32'h8000_0000,
                           32'hefff_ffff};

   cad_host_model i_cad_host_model (.sys_clk(sys_clk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   cad_datapath #(.GPR_DEPTH(32)) i_cad_datapath (.sys_clk(sys_clk), .nrst(nrst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

   // ****************************************
   // expectations and bus helpers
   // ****************************************
   // {overflow, carry, sum} of a three-input add
   function automatic logic [33:0] exp_add(input logic [31:0] a, input logic [31:0] b,
                                           input logic cin);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
      return {(a[31] == b[31]) && (s[31] != a[31]), s};
   endfunction : exp_add

   function automatic logic [31:0] enc(input logic [8:0] xo, input logic [4:0] t,
      input logic [4:0] a, input logic [4:0] b, input logic oe, input logic rc);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[cad_pkg::OPCD_LSB +: 6] = cad_pkg::OPCD_ARITH;
      w[cad_pkg::RT_LSB +: 5] = t;
      w[cad_pkg::RA_LSB +: 5] = a;
      w[cad_pkg::RB_LSB +: 5] = b;
      w[cad_pkg::OE_BIT] = oe;
      w[cad_pkg::XO_LSB +: 9] = xo;
      w[cad_pkg::RC_BIT] = rc;
      return w;
   endfunction : enc

   function automatic logic [7:0] gadr(input logic [4:0] n);
      return cad_pkg::OFF_GPR_BASE + {1'b0, n, 2'b00};
   endfunction : gadr

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      i_cad_host_model.bus_op(1'b1, a, d, unused);
   endtask : wr

   task automatic rdv(input logic [7:0] a, output logic [31:0] r);
      i_cad_host_model.bus_op(1'b0, a, 32'h0000_0000, r);
   endtask : rdv

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      rdv(a, r);
      chk(r, e);
   endtask : rd_chk

   task automatic set_flags(input logic [2:0] v);
      wr(cad_pkg::OFF_FLAGS, {29'h0000_0000, v});
      {so, ovf, carry} = v;
   endtask : set_flags

   // issue one add, update the shadow state and compare every result
   task automatic run_op(input logic ext, input logic [4:0] t, input logic [4:0] a,
                         input logic [4:0] b, input logic oe, input logic rc);
      logic [33:0] r;
      r = exp_add(gpr[a], gpr[b], ext & carry);
      wr(cad_pkg::OFF_INSTR, enc(ext ? cad_pkg::XO_ADD_EXTENDED : cad_pkg::XO_ADD_CARRYING,
         t, a, b, oe, rc));
      gpr[t] = r[31:0];
      carry = r[32];
      ovf = oe ? r[33] : ovf;
      so = so | (oe & r[33]);
      ovf_seen = ovf_seen | (oe & r[33]);
      if (rc) begin
         cr0 = {r[31], !r[31] && (r[31:0] != 32'h0000_0000), r[31:0] == 32'h0000_0000, so};
      end
      rd_chk(gadr(t), gpr[t]);
      rd_chk(cad_pkg::OFF_FLAGS, {29'h0000_0000, so, ovf, carry});
      rd_chk(cad_pkg::OFF_CR0, {28'h000_0000, cr0});
      rd_chk(cad_pkg::OFF_RESULT, r[31:0]);
   endtask : run_op

   task automatic report_and_stop();
      if (errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   // ****************************************
   // clock, timeout and main sequence
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles >= 20000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      seed = 32'hff38;
      errors = 0;
      check_count = 0;
      cycles = 0;
      {so, ovf, carry} = 3'h0;
      cr0 = 4'h0;
      ovf_seen = 1'b0;
      nrst = 1'b0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      // reset values, then an unmapped place
      for (int i = 0; i < 8; i++) begin
         if (i != 6) begin
            rd_chk(8'(i * 4), 32'h0000_0000);
         end
      end
      rd_chk(8'h40, 32'h0000_0000);
      for (int i = 0; i < 32; i++) begin
         gpr[i] = $random(seed);
         wr(gadr(5'(i)), gpr[i]);
      end
      // a write to lanes 0 and 2 only keeps the other bytes
      i_cad_host_model.be_next = 4'h5;
      wr(gadr(5'h09), 32'h1234_5678);
      i_cad_host_model.be_next = 4'hf;
      gpr[9] = {gpr[9][31:24], 8'h34, gpr[9][15:8], 8'h78};
      rd_chk(gadr(5'h09), gpr[9]);
      // corner operands through all eight forms
      for (int k = 0; k < 5; k++) begin
         gpr[1] = ca[k];
         gpr[2] = cb[k];
         wr(gadr(5'h01), gpr[1]);
         wr(gadr(5'h02), gpr[2]);
         set_flags({2'h0, k[0]});
         for (int f = 0; f < 8; f++) begin
            run_op(f[2], 5'h03, 5'h01, 5'h02, f[1], f[0]);
         end
      end
      // random operations with flag presets and operand changes
      repeat (40) begin
         rnd = $random(seed);
         if (rnd[19:18] == 2'h0) begin
            set_flags(rnd[22:20]);
         end
         if (rnd[23]) begin
            gpr[rnd[9:5]] = $random(seed);
            wr(gadr(rnd[9:5]), gpr[rnd[9:5]]);
         end
         run_op(rnd[15], rnd[4:0], rnd[9:5], rnd[14:10], rnd[16], rnd[17]);
      end
      wr(cad_pkg::OFF_CR0, 32'hffff_ffff);
      rd_chk(cad_pkg::OFF_CR0, {28'h000_0000, cr0});
      // bad instruction raises a masked then enabled interrupt
      rd_chk(cad_pkg::OFF_IRQ_STAT, {29'h0000_0000, 1'b0, ovf_seen, 1'b1});
      wr(cad_pkg::OFF_IRQ_EN, 32'h0000_0000);
      wr(cad_pkg::OFF_IRQ_CLR, 32'h0000_0007);
      wr(cad_pkg::OFF_INSTR, enc(9'h10a, 5'h05, 5'h01, 5'h02, 1'b1, 1'b1));
      rd_chk(gadr(5'h05), gpr[5]);
      rdv(cad_pkg::OFF_IRQ_STAT, rnd);
      chk(rnd & 32'h0000_0004, 32'h0000_0004);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      wr(cad_pkg::OFF_IRQ_EN, 32'h0000_0004);
      repeat (2) @(posedge sys_clk);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      wr(cad_pkg::OFF_IRQ_CLR, 32'h0000_0004);
      repeat (2) @(posedge sys_clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      // completion interrupt, then disabled
      wr(cad_pkg::OFF_IRQ_EN, 32'h0000_0001);
      run_op(1'b0, 5'h06, 5'h07, 5'h08, 1'b0, 1'b0);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      wr(cad_pkg::OFF_IRQ_EN, 32'h0000_0000);
      repeat (2) @(posedge sys_clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      report_and_stop();
   end
endmodule : tb_cad_datapath

bind cad_datapath cad_datapath_asserts #(.GPR_DEPTH(GPR_DEPTH)) i_cad_datapath_asserts (
   .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
